// [verilog/ics_cfg.svh]
// Purpose: Constants for the interrupt recognition and context-switch block.
// Assumes: Byte addresses are 14 bits wide, words are 16 bits.
// Notes: Definitions only.
`ifndef ICS_CFG_SVH
`define ICS_CFG_SVH
`define ICS_ADDR_W 14
`define ICS_MEM_BYTES 16384
`define ICS_VEC_RESET 14'h0000
`define ICS_VEC_L1 14'h0004
`define ICS_VEC_L2 14'h0008
`define ICS_VEC_L3 14'h000c
`define ICS_VEC_L4 14'h0010
`define ICS_VEC_BOOT 14'h3ffc
`define ICS_XOP_BASE 14'h0040
`define ICS_XOP_LAST 14'h007f
`define ICS_WR13_OFS 14'h001a
`define ICS_WR14_OFS 14'h001c
`define ICS_WR15_OFS 14'h001e
`define ICS_MASK_MSB 15
`define ICS_MASK_LSB 12
`define ICS_CODE_L4 3'h6
`define ICS_CODE_L3 3'h5
`define ICS_CODE_L2 3'h4
`define ICS_CODE_L1 3'h3
`define ICS_CODE_RST1 3'h1
`define ICS_CODE_RST0 3'h0
`define ICS_CODE_BOOT 3'h2
`define ICS_CODE_NONE 3'h7
`define ICS_RESET_MIN_CYC 3
`endif

// [verilog/ics_pkg.sv]
// Purpose: Types for the interrupt recognition and context-switch block.
// Assumes: Constants live in ics_cfg.svh.
// Notes: None.
package ics_pkg;
   typedef enum logic [3:0] {
      ICS_IDLE = 4'h0,
      ICS_VWP = 4'h1,
      ICS_VPC = 4'h3,
      ICS_SWP = 4'h2,
      ICS_SPC = 4'h6,
      ICS_SST = 4'h7,
      ICS_RWP = 4'h5,
      ICS_RPC = 4'h4,
      ICS_RST = 4'hc,
      ICS_HOLD = 4'hd
   } ics_state_t;

   typedef enum logic [1:0] {
      ICS_SRC_NONE = 2'h0,
      ICS_SRC_INT = 2'h1,
      ICS_SRC_BOOT = 2'h2,
      ICS_SRC_SW = 2'h3
   } ics_src_t;

   typedef struct packed {
      logic req;
      logic we;
      logic [13:0] addr;
      logic [15:0] wdata;
   } ics_mem_t;

   typedef struct packed {
      logic [15:0] pc;
      logic [15:0] wp;
      logic [15:0] st;
   } ics_ctx_t;

   typedef struct packed {
      ics_state_t state;
      ics_ctx_t ctx;
      ics_ctx_t old;
      logic [15:0] new_wp;
      logic [15:0] vec_wp;
      logic [2:0] code_s1;
      logic [2:0] code_s2;
      logic [1:0] rst_cnt;
      logic in_reset;
      logic inhibit;
      logic [3:0] new_mask;
      logic clr_all;
      logic is_return_restore_context;
      ics_mem_t mem;
      logic done;
   } ics_state_all_t;
endpackage : ics_pkg

// [verilog/ics_core.sv]
// Purpose: Interrupt recognition and context switching through memory.
// Assumes: Word memory port presents rdata in the same cycle as mem_ack for a granted read.
// Notes: The instruction engine signals completion on instr_done and requests
//        software context switches on sw_req.
`timescale 1ns/10ps
`include "ics_cfg.svh"

// Summary of operation
// - Memory is byte addressed; words sit on even addresses, high byte first.
// - The byte address space is at most 16,384 bytes.
// - Bytes 0 to 3 hold the reset workspace pointer and program counter.
// - The bootstrap trap vector sits at 3ffc.
// - Extended operation vectors come from 0040 through 007f.
// - External level vectors lie in 0004 through 0013.
// - Program counter points at next instruction and steps after each fetch.
// - Workspace register address is workspace pointer plus twice register number.
// - A full switch uses two fetch and three store words overall.
// - Context switch serves software calls, returns, interrupts, reset and bootstrap.
// - Five levels; level 0 is reset, levels 1 to 4 external.
// - Pending level at or below mask is taken after current instruction.
// - The vector pair is fetched first.
// - Old pointer, counter and status go into registers 13, 14, 15.
// - Mask becomes serviced level minus one.
// - No further interrupt until first service instruction has run.
// - Higher level during service causes a nested switch; return restores.
// - Code 110..011 are levels 4..1, 00x reset, 010 bootstrap, 111 none.
// - Levels vector at 0010, 000c, 0008, 0004; reset and bootstrap ignore mask.
// - Interrupt code inputs are synchronized before use.
// - Bootstrap trap runs after current instruction and clears the mask.
// - Reset code holds reset and blocks strobes; removal vectors at level 0.
module ics_core
   import ics_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic [2:0] interrupt_code_inputs,
   input wire logic instr_done,
   input wire logic instruction_acquire,
   input wire logic pc_step,
   input wire logic sw_req,
   input wire logic sw_is_return_restore_context,
   input wire logic [13:0] sw_vector,
   input wire logic [15:0] status_in,
   input wire logic status_load,
   output logic [13:0] mem_addr,
   output logic mem_req,
   output logic mem_we,
   output logic [15:0] mem_wdata,
   input wire logic mem_ack,
   input wire logic [15:0] mem_rdata,
   output logic [15:0] program_counter,
   output logic [15:0] workspace_ptr,
   output logic [15:0] processor_status,
   output logic switch_busy,
   output logic switch_done,
   output logic hold_reset,
   output logic write_strobe_allow,
   output logic bit_io_strobe_allow
);

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [13:0] reg_addr(input logic [15:0] wp, input logic [13:0] ofs);
      reg_addr = 14'(wp[13:0] + ofs) & 14'h3ffe;
   endfunction : reg_addr

   function automatic logic [2:0] code_level(input logic [2:0] code);
      case (code)
         `ICS_CODE_L4: code_level = 3'h4;
         `ICS_CODE_L3: code_level = 3'h3;
         `ICS_CODE_L2: code_level = 3'h2;
         `ICS_CODE_L1: code_level = 3'h1;
         default: code_level = 3'h0;
      endcase
   endfunction : code_level

   function automatic logic [13:0] level_vec(input logic [2:0] lvl);
      case (lvl)
         3'h4: level_vec = `ICS_VEC_L4;
         3'h3: level_vec = `ICS_VEC_L3;
         3'h2: level_vec = `ICS_VEC_L2;
         3'h1: level_vec = `ICS_VEC_L1;
         default: level_vec = `ICS_VEC_RESET;
      endcase
   endfunction : level_vec

   ics_state_all_t s_reg;
   ics_state_all_t s_next;
   logic [2:0] code;
   logic [2:0] lvl;
   logic is_reset;
   logic is_boot;
   logic int_ok;

   assign code = s_reg.code_s2;
   assign lvl = code_level(code);
   assign is_reset = (code == `ICS_CODE_RST0) || (code == `ICS_CODE_RST1);
   assign is_boot = (code == `ICS_CODE_BOOT);
   // Levels compare against mask; the inhibit flag covers the first service instruction.
   assign int_ok = (lvl != 3'h0) && ({1'b0, lvl} <= s_reg.ctx.st[`ICS_MASK_MSB:`ICS_MASK_LSB])
                   && !s_reg.inhibit;

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      s_next = s_reg;
      s_next.done = 1'b0;
      s_next.code_s1 = interrupt_code_inputs;
      s_next.code_s2 = s_reg.code_s1;
      if (status_load && s_reg.state == ICS_IDLE) begin
         s_next.ctx.st = status_in;
      end
      if (pc_step && s_reg.state == ICS_IDLE) begin
         s_next.ctx.pc = s_reg.ctx.pc + 16'h0002;
      end
      if (instr_done && s_reg.state == ICS_IDLE) begin
         s_next.inhibit = 1'b0;
      end
      case (s_reg.state)
         ICS_IDLE: begin
            if (is_reset) begin
               s_next.state = ICS_HOLD;
               s_next.in_reset = 1'b1;
            end else if (instr_done && is_boot) begin
               s_next.vec_wp = {2'h0, `ICS_VEC_BOOT};
               s_next.new_mask = 4'h0;
               s_next.clr_all = 1'b0;
               s_next.is_return_restore_context = 1'b0;
               s_next.state = ICS_VWP;
            end else if (instr_done && int_ok) begin
               s_next.vec_wp = {2'h0, level_vec(lvl)};
               s_next.new_mask = {1'b0, lvl} - 4'h1;
               s_next.clr_all = 1'b0;
               s_next.is_return_restore_context = 1'b0;
               s_next.state = ICS_VWP;
            end else if (sw_req) begin
               // Software switches: call and extended operation vector, return reads 13-15.
               s_next.vec_wp = {2'h0, sw_vector};
               s_next.is_return_restore_context = sw_is_return_restore_context;
               s_next.new_mask = s_reg.ctx.st[`ICS_MASK_MSB:`ICS_MASK_LSB];
               s_next.clr_all = 1'b0;
               s_next.state = sw_is_return_restore_context ? ICS_RWP : ICS_VWP;
            end
            s_next.old = s_reg.ctx;
            if (s_next.state == ICS_VWP || s_next.state == ICS_RWP) begin
               s_next.mem.req = 1'b1;
               s_next.mem.we = 1'b0;
               // Select by the state taken, so an interrupt that wins over a return still fetches its vector.
               s_next.mem.addr = (s_next.state == ICS_RWP) ? reg_addr(s_reg.ctx.wp, `ICS_WR13_OFS)
                                                                  : s_next.vec_wp[13:0];
            end
         end
         ICS_HOLD: begin
            // Held reset keeps both write strobes off until the code is removed and rst_cnt has counted to ICS_RESET_MIN_CYC - 1.
            if (!is_reset && s_reg.rst_cnt == 2'(`ICS_RESET_MIN_CYC - 1)) begin
               s_next.in_reset = 1'b0;
               s_next.vec_wp = {2'h0, `ICS_VEC_RESET};
               s_next.new_mask = 4'h0;
               s_next.clr_all = 1'b1;
               s_next.is_return_restore_context = 1'b0;
               s_next.state = ICS_VWP;
               s_next.mem = '{req: 1'b1, we: 1'b0, addr: `ICS_VEC_RESET, wdata: 16'h0000};
            end else if (s_reg.rst_cnt != 2'(`ICS_RESET_MIN_CYC - 1)) begin
               s_next.rst_cnt = s_reg.rst_cnt + 2'h1;
            end
         end
         ICS_VWP: if (mem_ack) begin
            s_next.new_wp = mem_rdata;
            s_next.state = ICS_VPC;
            s_next.mem.addr = s_reg.mem.addr + 14'h0002;
         end
         ICS_VPC: if (mem_ack) begin
            s_next.ctx.pc = mem_rdata;
            s_next.ctx.wp = s_reg.new_wp;
            s_next.state = ICS_SWP;
            s_next.mem = '{req: 1'b1, we: 1'b1, addr: reg_addr(s_reg.new_wp, `ICS_WR13_OFS),
                           wdata: s_reg.old.wp};
         end
         ICS_SWP: if (mem_ack) begin
            s_next.state = ICS_SPC;
            s_next.mem.addr = reg_addr(s_reg.ctx.wp, `ICS_WR14_OFS);
            s_next.mem.wdata = s_reg.old.pc;
         end
         ICS_SPC: if (mem_ack) begin
            s_next.state = ICS_SST;
            s_next.mem.addr = reg_addr(s_reg.ctx.wp, `ICS_WR15_OFS);
            s_next.mem.wdata = s_reg.old.st;
         end
         ICS_SST: if (mem_ack) begin
            s_next.state = ICS_IDLE;
            s_next.mem = '0;
            s_next.done = 1'b1;
            s_next.inhibit = 1'b1;
            if (s_reg.clr_all) begin
               s_next.ctx.st = 16'h0000;
            end else begin
               s_next.ctx.st[`ICS_MASK_MSB:`ICS_MASK_LSB] = s_reg.new_mask;
            end
         end
         ICS_RWP: if (mem_ack) begin
            s_next.new_wp = mem_rdata;
            s_next.state = ICS_RPC;
            s_next.mem.addr = reg_addr(s_reg.ctx.wp, `ICS_WR14_OFS);
         end
         ICS_RPC: if (mem_ack) begin
            s_next.ctx.pc = mem_rdata;
            s_next.state = ICS_RST;
            s_next.mem.addr = reg_addr(s_reg.ctx.wp, `ICS_WR15_OFS);
         end
         ICS_RST: if (mem_ack) begin
            s_next.ctx.st = mem_rdata;
            s_next.ctx.wp = s_reg.new_wp;
            s_next.state = ICS_IDLE;
            s_next.mem = '0;
            s_next.done = 1'b1;
         end
         default: s_next.state = ICS_IDLE;
      endcase
      if (is_reset && s_reg.state != ICS_HOLD) begin
         s_next.state = ICS_HOLD;
         s_next.in_reset = 1'b1;
         s_next.rst_cnt = 2'h0;
         s_next.mem = '0;
      end
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s_reg <= '{state: ICS_HOLD, code_s1: `ICS_CODE_NONE, code_s2: `ICS_CODE_NONE,
                    in_reset: 1'b1, default: '0};
      end else if (clk_en) begin
         s_reg <= s_next;
      end
   end

   assign mem_addr = s_reg.mem.addr;
   assign mem_req = s_reg.mem.req;
   assign mem_we = s_reg.mem.we;
   assign mem_wdata = s_reg.mem.wdata;
   assign program_counter = s_reg.ctx.pc;
   assign workspace_ptr = s_reg.ctx.wp;
   assign processor_status = s_reg.ctx.st;
   assign switch_busy = (s_reg.state != ICS_IDLE) && (s_reg.state != ICS_HOLD);
   assign switch_done = s_reg.done;
   assign hold_reset = s_reg.in_reset;
   assign write_strobe_allow = !s_reg.in_reset;
   assign bit_io_strobe_allow = !s_reg.in_reset;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   even_word_a: assert property (@(posedge clk) disable iff (!rst_n) mem_req |-> !mem_addr[0])
      else $error("Odd word address.");
   reset_block_a: assert property (@(posedge clk) disable iff (!rst_n)
      (clk_en && is_reset) |=> hold_reset && !write_strobe_allow)
      else $error("Reset code did not block strobes.");
   mask_set_a: assert property (@(posedge clk) disable iff (!rst_n)
      (clk_en && s_reg.state == ICS_SST && mem_ack && !is_reset && !s_reg.clr_all)
      |=> processor_status[15:12] == $past(s_reg.new_mask))
      else $error("Mask not set after switch.");
   store_order_a: assert property (@(posedge clk) disable iff (!rst_n)
      (clk_en && s_reg.state == ICS_VPC && mem_ack && !is_reset)
      |=> mem_we && mem_addr == 14'($past(s_reg.new_wp) & 16'h3ffe) + `ICS_WR13_OFS && mem_wdata == s_reg.old.wp)
      else $error("Old pointer not stored first.");
   vec_first_a: assert property (@(posedge clk) disable iff (!rst_n)
      (s_reg.state == ICS_VWP) |-> mem_req && !mem_we)
      else $error("Vector not read first.");
   inhibit_set_a: assert property (@(posedge clk) disable iff (!rst_n)
      switch_done && !s_reg.is_return_restore_context |-> s_reg.inhibit)
      else $error("Inhibit not set after switch.");
   status_clr_a: assert property (@(posedge clk) disable iff (!rst_n)
      (switch_done && s_reg.clr_all) |-> processor_status == 16'h0000)
      else $error("Status not cleared after reset.");
   level_vec_a: assert property (@(posedge clk) disable iff (!rst_n)
      (clk_en && s_reg.state == ICS_IDLE && instr_done && int_ok && !is_reset && !is_boot)
      |=> mem_addr == level_vec($past(lvl)))
      else $error("Wrong level vector.");

   // ----------------------------------------
   // Checks on vectors and stores
   // ----------------------------------------
   boot_vec_a: assert property (@(posedge clk) disable iff (!rst_n)
      (clk_en && s_reg.state == ICS_IDLE && instr_done && is_boot)
      |=> mem_req && !mem_we && mem_addr == `ICS_VEC_BOOT)
      else $error("Bootstrap vector not fetched.");
   reset_vec_a: assert property (@(posedge clk) disable iff (!rst_n)
      (clk_en && s_reg.state == ICS_HOLD && !is_reset && s_reg.rst_cnt == 2'(`ICS_RESET_MIN_CYC - 1))
      |=> mem_req && !mem_we && mem_addr == `ICS_VEC_RESET && !hold_reset)
      else $error("Reset vector not fetched.");
   vec_pc_a: assert property (@(posedge clk) disable iff (!rst_n)
      (clk_en && s_reg.state == ICS_VWP && mem_ack && !is_reset)
      |=> mem_req && !mem_we && mem_addr == $past(mem_addr) + 14'h0002)
      else $error("Vector counter word not fetched next.");
   store_pc_a: assert property (@(posedge clk) disable iff (!rst_n)
      (clk_en && s_reg.state == ICS_SWP && mem_ack && !is_reset)
      |=> mem_we && mem_addr == reg_addr(workspace_ptr, `ICS_WR14_OFS) && mem_wdata == s_reg.old.pc)
      else $error("Old counter not stored second.");
   store_st_a: assert property (@(posedge clk) disable iff (!rst_n)
      (clk_en && s_reg.state == ICS_SPC && mem_ack && !is_reset)
      |=> mem_we && mem_addr == reg_addr(workspace_ptr, `ICS_WR15_OFS) && mem_wdata == s_reg.old.st)
      else $error("Old status not stored third.");
   done_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
      switch_done |-> !switch_busy && !mem_req)
      else $error("Memory still busy after switch.");

   // ----------------------------------------
   // Checks on recognition
   // ----------------------------------------
   sync_path_a: assert property (@(posedge clk) disable iff (!rst_n)
      clk_en |=> s_reg.code_s2 == $past(s_reg.code_s1))
      else $error("Code synchroniser skipped a stage.");
   pc_step_a: assert property (@(posedge clk) disable iff (!rst_n)
      (clk_en && s_reg.state == ICS_IDLE && pc_step) |=> program_counter == $past(program_counter) + 16'h0002)
      else $error("Program counter did not step.");
   hold_quiet_a: assert property (@(posedge clk) disable iff (!rst_n)
      (s_reg.state == ICS_HOLD) |-> hold_reset && !mem_req && !bit_io_strobe_allow)
      else $error("Held reset let a strobe or request through.");
   mask_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
      (clk_en && s_reg.state == ICS_IDLE && instr_done && !is_reset && !is_boot && !sw_req
       && ({1'b0, lvl} > s_reg.ctx.st[`ICS_MASK_MSB:`ICS_MASK_LSB])) |=> !switch_busy)
      else $error("Masked level was taken.");
   inhibit_block_a: assert property (@(posedge clk) disable iff (!rst_n)
      (clk_en && s_reg.state == ICS_IDLE && s_reg.inhibit && !is_reset && !is_boot && !sw_req)
      |=> !switch_busy)
      else $error("Interrupt taken while inhibited.");
   return_read_a: assert property (@(posedge clk) disable iff (!rst_n)
      (clk_en && s_reg.state == ICS_IDLE && sw_req && sw_is_return_restore_context && !instr_done && !is_reset)
      |=> mem_req && !mem_we && mem_addr == reg_addr($past(workspace_ptr), `ICS_WR13_OFS))
      else $error("Return did not read register 13 first.");
endmodule : ics_core

// [tb/ics_mem_model.sv]
// Purpose: Word memory that answers the context-switch block's requests.
// Assumes: One request at a time, held until mem_ack.
// Notes: Latency of 0 to 3 idle cycles is chosen by lat.
`timescale 1ns/10ps
module ics_mem_model
   import ics_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [13:0] mem_addr,
   input wire logic mem_req,
   input wire logic mem_we,
   input wire logic [15:0] mem_wdata,
   input wire logic [1:0] lat,
   output logic mem_ack,
   output logic [15:0] mem_rdata
);
   logic [15:0] mem [0:8191];
   logic [1:0] wait_reg;
   initial begin
      mem_ack = 1'b0;
      mem_rdata = 16'h5a5a;
      wait_reg = 2'h0;
      for (int i = 0; i < 8192; i++) begin
         mem[i] = {4'h1, i[10:0], 1'b0};
      end
   end
   // Read data is inverted on every cycle except a read answer so stale values never match by luck.
   always @(posedge clk) begin
      if (!rst_n || mem_ack || !mem_req) begin
         mem_ack <= 1'b0;
         wait_reg <= 2'h0;
         mem_rdata <= ~mem_rdata;
      end else if (wait_reg >= lat) begin
         mem_ack <= 1'b1;
         if (mem_we) begin
            mem[mem_addr[13:1]] <= mem_wdata;
            mem_rdata <= ~mem_rdata;
         end else begin
            mem_rdata <= mem[mem_addr[13:1]];
         end
      end else begin
         wait_reg <= wait_reg + 2'h1;
         mem_rdata <= ~mem_rdata;
      end
   end
endmodule : ics_mem_model

// [tb/interrupt_context_switch_test.sv]
// Purpose: Self-checking bench for interrupt recognition and context switching.
// Assumes: Memory word at byte address a holds {1, a[11:0]} until written.
// Notes: Expected accesses and contexts are queued and checked by a watcher.
`timescale 1ns/10ps
`include "ics_cfg.svh"
module interrupt_context_switch_test
   import ics_pkg::*;
;
   logic clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, instr_done = 1'b0, pc_step = 1'b0;
   logic sw_req = 1'b0, sw_is_return_restore_context = 1'b0, status_load = 1'b0, mem_chk = 1'b0;
   logic [2:0] code = 3'h0;
   logic [13:0] sw_vector = 14'h0, mem_addr;
   logic [15:0] status_in = 16'h0, mem_wdata, mem_rdata, program_counter, workspace_ptr, processor_status;
   logic [7:0] seed = 8'h1d;
   logic [1:0] lat = 2'h0;
   logic mem_req, mem_we, mem_ack, switch_busy, switch_done, hold_reset, write_strobe_allow, bit_io_strobe_allow;
   int n_errors = 0, n_checks = 0;
   ics_mem_t exp_mem[$];
   ics_ctx_t exp_ctx[$], stack[$], ctx;
   logic [2:0] codes [4] = '{`ICS_CODE_L4, `ICS_CODE_L3, `ICS_CODE_L2, `ICS_CODE_L1};
   logic [13:0] vecs [4] = '{`ICS_VEC_L4, `ICS_VEC_L3, `ICS_VEC_L2, `ICS_VEC_L1};

   ics_core i_dut(.clk, .rst_n, .clk_en, .interrupt_code_inputs(code), .instr_done, .instruction_acquire(instr_done),
      .pc_step, .sw_req, .sw_is_return_restore_context, .sw_vector, .status_in, .status_load, .mem_addr, .mem_req, .mem_we,
      .mem_wdata, .mem_ack, .mem_rdata, .program_counter, .workspace_ptr, .processor_status, .switch_busy,
      .switch_done, .hold_reset, .write_strobe_allow, .bit_io_strobe_allow);
   ics_mem_model i_mem(.clk, .rst_n, .mem_addr, .mem_req, .mem_we, .mem_wdata, .lat, .mem_ack, .mem_rdata);

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [7:0] lfsr_next(logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction : lfsr_next
   function automatic logic [15:0] word_at(logic [13:0] a);
      return {4'h1, a[11:0]};
   endfunction : word_at
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask : cyc
   task automatic pulse(ref logic s);
      s = 1'b1;
      @(negedge clk);
      s = 1'b0;
      @(negedge clk);
   endtask : pulse
   task automatic check_bit(input string what, input logic e, input logic g);
      n_checks++;
      if (g !== e) begin
         n_errors++;
         $display("[FAIL] %s expected %b seen %b", what, e, g);
      end
   endtask : check_bit
   task automatic check_mem(input ics_mem_t e, input ics_mem_t g);
      n_checks++;
      if (g !== e) begin
         n_errors++;
         $display("[FAIL] memory access expected %h seen %h", e, g);
      end
   endtask : check_mem
   task automatic check_ctx(input ics_ctx_t e, input ics_ctx_t g);
      n_checks++;
      if (g !== e) begin
         n_errors++;
         $display("[FAIL] context expected %h seen %h", e, g);
      end
   endtask : check_ctx
   task automatic expect_switch(input logic [13:0] vec, input logic [15:0] st);
      logic [13:0] w;
      w = 14'(word_at(vec));
      exp_mem.push_back({2'b10, vec, 16'h0});
      exp_mem.push_back({2'b10, vec + 14'h2, 16'h0});
      exp_mem.push_back({2'b11, w + `ICS_WR13_OFS, ctx.wp});
      exp_mem.push_back({2'b11, w + `ICS_WR14_OFS, ctx.pc});
      exp_mem.push_back({2'b11, w + `ICS_WR15_OFS, ctx.st});
      stack.push_back(ctx);
      ctx = '{pc: word_at(vec + 14'h2), wp: word_at(vec), st: st};
      exp_ctx.push_back(ctx);
   endtask : expect_switch
   task automatic expect_return;
      exp_mem.push_back({2'b10, ctx.wp[13:0] + `ICS_WR13_OFS, 16'h0});
      exp_mem.push_back({2'b10, ctx.wp[13:0] + `ICS_WR14_OFS, 16'h0});
      exp_mem.push_back({2'b10, ctx.wp[13:0] + `ICS_WR15_OFS, 16'h0});
      ctx = stack.pop_back();
      exp_ctx.push_back(ctx);
   endtask : expect_return
   task automatic settle;
      for (int k = 0; k < 300 && (exp_ctx.size() > 0 || switch_busy !== 1'b0); k++) @(negedge clk);
      check_bit("switch finished", 1'b0, exp_ctx.size() > 0 || exp_mem.size() > 0);
   endtask : settle
   task automatic no_take;
      cyc(8);
      check_bit("switch started", 1'b0, switch_busy);
   endtask : no_take
   task automatic reset_seq(input logic [2:0] rc);
      code = rc;
      cyc(5);
      check_bit("hold reset", 1'b1, hold_reset);
      check_bit("write strobe", 1'b0, write_strobe_allow);
      check_bit("bit strobe", 1'b0, bit_io_strobe_allow);
      stack.delete();
      ctx = '{pc: word_at(14'h2), wp: word_at(14'h0), st: 16'h0};
      exp_ctx.push_back(ctx);
      code = `ICS_CODE_NONE;
      settle();
      check_bit("hold released", 1'b0, hold_reset);
      check_bit("write strobe back", 1'b1, write_strobe_allow);
      check_bit("bit strobe back", 1'b1, bit_io_strobe_allow);
   endtask : reset_seq
   task automatic tally_and_finish;
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : tally_and_finish

   // ----------------------------------------
   // Clock, random latency, watcher
   // ----------------------------------------
   always #10 clk = ~clk;
   always @(negedge clk) begin
      seed <= lfsr_next(seed);
      lat <= seed[1:0];
   end
   always @(posedge clk) begin
      if (rst_n && mem_chk && mem_req && mem_ack) begin
         check_mem(exp_mem.pop_front(), {1'b1, mem_we, mem_addr, mem_we ? mem_wdata : 16'h0});
      end
      if (rst_n && switch_done) begin
         check_ctx(exp_ctx.pop_front(), {program_counter, workspace_ptr, processor_status});
      end
   end
   initial begin
      #400000;
      n_errors++;
      tally_and_finish();
   end

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   initial begin
      cyc(20);
      rst_n = 1'b1;
      reset_seq(`ICS_CODE_RST0);
      mem_chk = 1'b1;
      status_in = 16'hf000;
      pulse(status_load);
      ctx.st = 16'hf000;
      pulse(pc_step);
      ctx.pc = ctx.pc + 16'h2;
      clk_en = 1'b0;
      pulse(pc_step);
      clk_en = 1'b1;
      check_ctx(ctx, {program_counter, workspace_ptr, processor_status});
      pulse(instr_done);
      for (int i = 0; i < 4; i++) begin
         code = codes[i];
         cyc(3);
         expect_switch(vecs[i], {4'h3 - i[3:0], 12'h0});
         pulse(instr_done);
         settle();
         code = `ICS_CODE_NONE;
         pulse(instr_done);
         pulse(status_load);
         ctx.st = 16'hf000;
      end
      code = `ICS_CODE_L2;
      cyc(3);
      expect_switch(`ICS_VEC_L2, 16'h1000);
      pulse(instr_done);
      settle();
      code = `ICS_CODE_L1;
      cyc(3);
      pulse(instr_done);
      no_take();
      expect_switch(`ICS_VEC_L1, 16'h0000);
      pulse(instr_done);
      settle();
      code = `ICS_CODE_L2;
      pulse(instr_done);
      pulse(instr_done);
      no_take();
      code = `ICS_CODE_BOOT;
      cyc(3);
      expect_switch(`ICS_VEC_BOOT, 16'h0000);
      pulse(instr_done);
      settle();
      code = `ICS_CODE_NONE;
      sw_vector = `ICS_XOP_BASE;
      expect_switch(`ICS_XOP_BASE, ctx.st);
      pulse(sw_req);
      settle();
      sw_is_return_restore_context = 1'b1;
      expect_return();
      pulse(sw_req);
      settle();
      sw_is_return_restore_context = 1'b0;
      mem_chk = 1'b0;
      reset_seq(`ICS_CODE_RST1);
      tally_and_finish();
   end
endmodule : interrupt_context_switch_test
